/* core/armtc_ctrl.sv */
// armtc_ctrl: register file, trigger, timing, result alignment,
// threshold monitors and dma request around a converter core.
// assumes classic wishbone on the same clock; the core presents
// its raw 12-bit result while convert_r is high, valid at the end.
//
// Function
// - monitor zero active only when enabled
// - out-of-range result sets monitor zero flag
// - flag and irq enable raise interrupt
// - monitor zero compares raw, pre-alignment result
// - monitor zero: one channel or all
// - monitor one enabled per channel bitmap
// - monitor one limits share one register
// - result stored left or right aligned
// - per-channel three-bit sample time
// - twelve bit: sample time plus 12.5
// - rising edge of trigger starts conversion
// - source bit: 0 hardware, 1 software
// - dma request after each conversion
// - second instance never requests dma
// - temp sensor bit powers channel 16
// - reference bit connects channel 17
// - result twelve bits, unused lsbs zero
// - conversion time shrinks with resolution
// - converter held in reset while off
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module armtc_ctrl #(
  parameter bit SECOND_INSTANCE = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hw_trigger_input,
  input wire logic [11:0] core_result,
  output logic analog_power_r,
  output logic sample_r,
  output logic convert_r,
  output logic [4:0] mux_channel_r,
  output logic temp_sensor_on_r,
  output logic internal_ref_on_r,
  output logic dma_req_r,
  output logic irq_r
);
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } armtc_state_t;

  logic [31:0] ctl_a_r;
  logic [31:0] ctl_b_r;
  logic [2:0] status_r;
  logic [2:0] samp_r [armtc_pkg::NCH];
  logic [11:0] m0_high_r;
  logic [11:0] m0_low_r;
  logic [31:0] m1_lim_r;
  logic [17:0] m1_sel_r;
  logic [1:0] res_r;
  logic [15:0] data_r;
  logic [4:0] chan_r;
  logic hw_trig_d_r;
  logic sw_start_d_r;
  armtc_state_t state_r;
  logic [9:0] cnt_r;
  logic [4:0] conv_ch_r;
  logic [31:0] rd_nxt;

  // writes land at the edge where the master samples ack high
  wire logic wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire logic rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  wire logic conv_on = ctl_b_r[armtc_pkg::B_ON];

  // byte-lane merge for writes
  function automatic logic [31:0] merge
  (
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        v[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return v;
  endfunction : merge

  // ---------------- wishbone handshake ----------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      // one-cycle ack, dropped the cycle after it was given
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      wb_dat_o <= rd_nxt;
    end
  end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      armtc_pkg::OFS_CTL_A: rd_nxt = ctl_a_r;
      armtc_pkg::OFS_CTL_B: rd_nxt = ctl_b_r;
      armtc_pkg::OFS_STATUS: rd_nxt = {29'h0000_0000, status_r};
      armtc_pkg::OFS_SAMP_A:
      begin
        for (int i = 0; i < armtc_pkg::BANK_A_CH; i++)
        begin
          rd_nxt[i*3 +: 3] = samp_r[i];
        end
      end
      armtc_pkg::OFS_SAMP_B:
      begin
        for (int i = armtc_pkg::BANK_A_CH; i < armtc_pkg::NCH; i++)
        begin
          rd_nxt[(i-armtc_pkg::BANK_A_CH)*3 +: 3] = samp_r[i];
        end
      end
      armtc_pkg::OFS_M0_HIGH: rd_nxt = {20'h0_0000, m0_high_r};
      armtc_pkg::OFS_M0_LOW: rd_nxt = {20'h0_0000, m0_low_r};
      armtc_pkg::OFS_M1_LIM: rd_nxt = m1_lim_r;
      armtc_pkg::OFS_M1_SEL: rd_nxt = {14'h0000, m1_sel_r};
      armtc_pkg::OFS_OVS:
        rd_nxt[armtc_pkg::OVS_RES_LSB +: 2] = res_r;
      armtc_pkg::OFS_DATA: rd_nxt = {16'h0000, data_r};
      armtc_pkg::OFS_CHAN: rd_nxt = {27'h000_0000, chan_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctl_a_r <= 32'h0000_0000;
      ctl_b_r <= 32'h0000_0000;
      m0_high_r <= 12'hFFF;
      m0_low_r <= 12'h000;
      m1_lim_r <= 32'h0FFF_0000;
      m1_sel_r <= 18'h0_0000;
      res_r <= 2'h0;
      chan_r <= 5'h00;
    end
    else
    begin
      if (wr_en)
      begin
        case (wb_adr_i)
          armtc_pkg::OFS_CTL_A:
            ctl_a_r <= merge(ctl_a_r, wb_dat_i, wb_sel_i);
          armtc_pkg::OFS_CTL_B:
            ctl_b_r <= merge(ctl_b_r, wb_dat_i, wb_sel_i);
          armtc_pkg::OFS_M0_HIGH:
            m0_high_r <= 12'(merge({20'h0_0000, m0_high_r}, wb_dat_i,
              wb_sel_i));
          armtc_pkg::OFS_M0_LOW:
            m0_low_r <= 12'(merge({20'h0_0000, m0_low_r}, wb_dat_i,
              wb_sel_i));
          armtc_pkg::OFS_M1_LIM:
            m1_lim_r <= merge(m1_lim_r, wb_dat_i, wb_sel_i)
              & 32'h0FFF_0FFF;
          armtc_pkg::OFS_M1_SEL:
            m1_sel_r <= 18'(merge({14'h0000, m1_sel_r}, wb_dat_i,
              wb_sel_i));
          armtc_pkg::OFS_OVS:
          begin
            // resolution only takes effect while off
            if (!conv_on && wb_sel_i[0])
            begin
              res_r <= wb_dat_i[armtc_pkg::OVS_RES_LSB +: 2];
            end
          end
          armtc_pkg::OFS_CHAN:
          begin
            if (wb_sel_i[0])
            begin
              chan_r <= wb_dat_i[4:0];
            end
          end
          default:
          begin
          end
        endcase
      end
      // software start bit clears itself once a conversion begins
      if (state_r == ST_SAMPLE)
      begin
        ctl_b_r[armtc_pkg::B_SWST] <= 1'b0;
      end
    end
  end

  // per-channel sample time codes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < armtc_pkg::NCH; i++)
      begin
        samp_r[i] <= 3'h0;
      end
    end
    else if (wr_en && wb_adr_i == armtc_pkg::OFS_SAMP_A)
    begin
      for (int i = 0; i < armtc_pkg::BANK_A_CH; i++)
      begin
        if (wb_sel_i[(i*3)/8] && wb_sel_i[(i*3+2)/8])
        begin
          samp_r[i] <= wb_dat_i[i*3 +: 3];
        end
      end
    end
    else if (wr_en && wb_adr_i == armtc_pkg::OFS_SAMP_B)
    begin
      for (int i = armtc_pkg::BANK_A_CH; i < armtc_pkg::NCH; i++)
      begin
        if (wb_sel_i[((i-armtc_pkg::BANK_A_CH)*3)/8]
          && wb_sel_i[((i-armtc_pkg::BANK_A_CH)*3+2)/8])
        begin
          samp_r[i] <= wb_dat_i[(i-armtc_pkg::BANK_A_CH)*3 +: 3];
        end
      end
    end
  end

  // ---------------- trigger and conversion timing ----------------
  wire logic hw_rise = hw_trigger_input & ~hw_trig_d_r;
  wire logic sw_rise = ctl_b_r[armtc_pkg::B_SWST] & ~sw_start_d_r;
  wire logic trig = ctl_b_r[armtc_pkg::B_TSRC] ? sw_rise : hw_rise;

  logic [9:0] conv_half;
  always_comb
  begin
    case (armtc_pkg::armtc_res_t'(res_r))
      armtc_pkg::RES_12: conv_half = armtc_pkg::CONV_HALF_12;
      armtc_pkg::RES_10: conv_half = armtc_pkg::CONV_HALF_10;
      armtc_pkg::RES_8: conv_half = armtc_pkg::CONV_HALF_8;
      armtc_pkg::RES_6: conv_half = armtc_pkg::CONV_HALF_6;
      default: conv_half = armtc_pkg::CONV_HALF_12;
    endcase
  end

  // half-cycle sample and conversion parts sum to whole cycles
  wire logic [9:0] samp_half = armtc_pkg::SAMP_HALF[samp_r[chan_r]];
  wire logic [9:0] samp_cyc = 10'((samp_half + 10'h001) >> 1);
  wire logic [9:0] conv_cyc = 10'((conv_half - 10'h001) >> 1);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hw_trig_d_r <= 1'b0;
      sw_start_d_r <= 1'b0;
    end
    else
    begin
      hw_trig_d_r <= hw_trigger_input;
      sw_start_d_r <= ctl_b_r[armtc_pkg::B_SWST];
    end
  end

  wire logic conv_end = state_r == ST_CONVERT && cnt_r == 10'h001;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 10'h000;
      conv_ch_r <= 5'h00;
    end
    else if (!conv_on)
    begin
      // held in reset while the converter is off
      state_r <= ST_IDLE;
      cnt_r <= 10'h000;
      conv_ch_r <= 5'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (trig)
          begin
            state_r <= ST_SAMPLE;
            cnt_r <= samp_cyc;
            conv_ch_r <= chan_r;
          end
        end
        ST_SAMPLE:
        begin
          if (cnt_r == 10'h001)
          begin
            state_r <= ST_CONVERT;
            cnt_r <= conv_cyc;
          end
          else
          begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        ST_CONVERT:
        begin
          if (cnt_r == 10'h001)
          begin
            state_r <= ST_IDLE;
            cnt_r <= 10'h000;
          end
          else
          begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------- result path ----------------
  logic [11:0] res_mask;
  always_comb
  begin
    case (armtc_pkg::armtc_res_t'(res_r))
      armtc_pkg::RES_10: res_mask = armtc_pkg::MASK_10;
      armtc_pkg::RES_8: res_mask = armtc_pkg::MASK_8;
      armtc_pkg::RES_6: res_mask = armtc_pkg::MASK_6;
      default: res_mask = armtc_pkg::MASK_12;
    endcase
  end

  wire logic [11:0] raw = core_result & res_mask;
  wire logic m0_out = raw > m0_high_r || raw < m0_low_r;
  wire logic m1_out = raw > m1_lim_r[armtc_pkg::M1_HIGH_LSB +: 12]
    || raw < m1_lim_r[11:0];
  wire logic m0_hit = ctl_a_r[armtc_pkg::A_M0_EN] && m0_out
    && (!ctl_a_r[armtc_pkg::A_M0_SC]
    || ctl_a_r[armtc_pkg::A_M0_CHSEL +: 5] == conv_ch_r);
  wire logic m1_hit = conv_ch_r < 5'(armtc_pkg::NCH)
    && m1_sel_r[conv_ch_r] && m1_out;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      data_r <= 16'h0000;
    end
    else if (!conv_on)
    begin
      data_r <= 16'h0000;
    end
    else if (conv_end)
    begin
      // alignment only affects storage, never the monitors
      data_r <= ctl_b_r[armtc_pkg::B_ALIGN]
        ? {raw, 4'h0} : {4'h0, raw};
    end
  end

  // sticky flags cleared by writing 0; a new event wins the clear
  logic [2:0] status_nxt;
  always_comb
  begin
    status_nxt = status_r;
    if (wr_en && wb_adr_i == armtc_pkg::OFS_STATUS && wb_sel_i[0])
    begin
      status_nxt = status_r & wb_dat_i[2:0];
    end
    if (conv_end)
    begin
      status_nxt[armtc_pkg::S_EOC] = 1'b1;
      if (m0_hit)
      begin
        status_nxt[armtc_pkg::S_M0_EV] = 1'b1;
      end
      if (m1_hit)
      begin
        status_nxt[armtc_pkg::S_M1_EV] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status_r <= 3'h0;
    end
    else if (!conv_on)
    begin
      status_r <= 3'h0;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      analog_power_r <= 1'b0;
      sample_r <= 1'b0;
      convert_r <= 1'b0;
      mux_channel_r <= 5'h00;
      temp_sensor_on_r <= 1'b0;
      internal_ref_on_r <= 1'b0;
      dma_req_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      analog_power_r <= conv_on;
      sample_r <= state_r == ST_SAMPLE;
      convert_r <= state_r == ST_CONVERT;
      mux_channel_r <= (state_r == ST_IDLE) ? chan_r : conv_ch_r;
      // sensor powered down when its bit is clear
      temp_sensor_on_r <= ctl_b_r[armtc_pkg::B_TEMP];
      internal_ref_on_r <= ctl_b_r[armtc_pkg::B_IREF];
      dma_req_r <= conv_end && ctl_b_r[armtc_pkg::B_DMA]
        && !SECOND_INSTANCE;
      irq_r <= status_nxt[armtc_pkg::S_M0_EV]
        && ctl_a_r[armtc_pkg::A_M0_IE];
    end
  end
endmodule : armtc_ctrl

/* pkg/armtc_pkg.sv */
// armtc_pkg: register map, field positions and timing constants
// for the converter control block.
// assumes a 32-bit classic wishbone slave with word-aligned byte offsets.
package armtc_pkg;
  localparam logic [5:0] OFS_CTL_A = 6'h00;
  localparam logic [5:0] OFS_CTL_B = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_SAMP_A = 6'h0C;
  localparam logic [5:0] OFS_SAMP_B = 6'h10;
  localparam logic [5:0] OFS_M0_HIGH = 6'h14;
  localparam logic [5:0] OFS_M0_LOW = 6'h18;
  localparam logic [5:0] OFS_M1_LIM = 6'h1C;
  localparam logic [5:0] OFS_M1_SEL = 6'h20;
  localparam logic [5:0] OFS_OVS = 6'h24;
  localparam logic [5:0] OFS_DATA = 6'h28;
  localparam logic [5:0] OFS_CHAN = 6'h2C;

  // control a fields
  localparam int A_M0_CHSEL = 0;
  localparam int A_M0_IE = 6;
  localparam int A_M0_SC = 9;
  localparam int A_M0_EN = 23;
  // control b fields
  localparam int B_ON = 0;
  localparam int B_DMA = 8;
  localparam int B_ALIGN = 11;
  localparam int B_TSRC = 17;
  localparam int B_SWST = 22;
  localparam int B_TEMP = 23;
  localparam int B_IREF = 24;
  // status fields
  localparam int S_M0_EV = 0;
  localparam int S_M1_EV = 1;
  localparam int S_EOC = 2;
  // monitor 1 limits: low in [11:0], high in [27:16]
  localparam int M1_HIGH_LSB = 16;
  // oversample control: resolution in [3:2]
  localparam int OVS_RES_LSB = 2;

  localparam int NCH = 18;
  localparam int BANK_A_CH = 10;
  localparam int CH_TEMP = 16;
  localparam int CH_IREF = 17;
  localparam int RES_W = 12;
  localparam int ALIGN_SHIFT = 4;

  typedef enum logic [1:0]
  {
    RES_12 = 2'b00,
    RES_10 = 2'b01,
    RES_8 = 2'b10,
    RES_6 = 2'b11
  } armtc_res_t;

  // conversion time in half clock cycles: 25, 21, 17, 13 (12.5, 10.5, 8.5, 6.5 cycles)
  localparam logic [9:0] CONV_HALF_12 = 10'h019;
  localparam logic [9:0] CONV_HALF_10 = 10'h015;
  localparam logic [9:0] CONV_HALF_8 = 10'h011;
  localparam logic [9:0] CONV_HALF_6 = 10'h00D;
  // sample time per 3-bit code, in half cycles (plain defaults)
  localparam logic [9:0] SAMP_HALF [8] = '{
    10'h005, 10'h00D, 10'h019, 10'h031,
    10'h061, 10'h0C1, 10'h181, 10'h301};

  localparam logic [11:0] MASK_12 = 12'hFFF;
  localparam logic [11:0] MASK_10 = 12'hFFC;
  localparam logic [11:0] MASK_8 = 12'hFF0;
  localparam logic [11:0] MASK_6 = 12'hFC0;
endpackage : armtc_pkg

/* test/armtc_core_model.sv */
// armtc_core_model: behavioural converter core feeding raw results.
// assumes the control block samples core_result on its last convert cycle.
`timescale 1ns/10ps
module armtc_core_model (
  input wire logic clock,
  input wire logic convert_r,
  input wire logic [11:0] level,
  output logic [11:0] core_result
);
  logic [11:0] junk = 12'h0A5A;

  // outside conversion the lines carry a changing pattern, not the result
  always @(posedge clock)
    junk <= ~junk;

  assign core_result = convert_r ? level : junk;
endmodule : armtc_core_model

/* test/armtc_ctrl_chk.sv */
// armtc_ctrl_chk: timing checks on the control block's ports.
// assumes one clock domain with rst active high.
`timescale 1ns/10ps
module armtc_ctrl_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic analog_power_r,
  input wire logic sample_r,
  input wire logic convert_r,
  input wire logic dma_req_r
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);

  a_ack_answer: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dma_single: assert property (dma_req_r |=> !dma_req_r)
    else $error("dma request longer than one cycle");
  a_dma_cause: assert property
    (dma_req_r |-> convert_r ##1 !convert_r)
    else $error("dma request without finished conversion");
  a_off_idle: assert property
    (!analog_power_r && !$past(analog_power_r) |-> !sample_r && !convert_r)
    else $error("converter active while off");
  a_no_overlap: assert property (!(sample_r && convert_r))
    else $error("sample and convert together");
  a_sample_min: assert property ($rose(sample_r) |-> sample_r[*3])
    else $error("sampling shorter than three cycles");
  a_conv_min: assert property ($rose(convert_r) |-> convert_r[*6])
    else $error("conversion shorter than six cycles");
  a_conv_start: assert property
    ($fell(sample_r) && analog_power_r |-> convert_r)
    else $error("sampling not followed by conversion");
endmodule : armtc_ctrl_chk

bind armtc_ctrl armtc_ctrl_chk armtc_ctrl_chk_i (
  .clock(clock),
  .rst(rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .analog_power_r(analog_power_r),
  .sample_r(sample_r),
  .convert_r(convert_r),
  .dma_req_r(dma_req_r)
);

/* test/armtc_ctrl_tb_top.sv */
// armtc_ctrl_tb_top: register-level tests of the converter control block.
// assumes the core model answers every conversion; dma is enabled during every conversion.
`timescale 1ns/10ps
module armtc_ctrl_tb_top;
  localparam logic [31:0] ON = 32'h0000_0101;
  localparam logic [31:0] SW = 32'h0002_0000;
  localparam logic [31:0] TI = 32'h0180_0000;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic hwt = 1'h0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dw = 32'h0000_0000;
  logic [31:0] dr, rdat;
  logic [11:0] lvl = 12'h000;
  logic [11:0] core;
  logic ack, pwr, smp, cnv, ts, ir, dma, irq;
  logic [4:0] mux;
  logic dma2;
  int n2 = 0;
  int miscompares = 0;
  int compares = 0;
  int s, c;
  int ct [4] = '{12, 10, 8, 6};
  logic [11:0] sv [5] = '{12'h800, 12'h0FF, 12'hFFF, 12'hFFF, 12'h050};
  logic [31:0] sa [5] = '{32'h0080_0250, 32'h0080_0250, 32'h0080_0245,
    32'h0000_0250, 32'h0080_0045};
  logic [11:0] sd [5] = '{12'h800, 12'hFF0, 12'hFFF, 12'hFFF, 12'h050};
  logic [2:0] ss [5] = '{3'h6, 3'h7, 3'h6, 3'h6, 3'h7};

  always #25 clock = ~clock;

  armtc_ctrl armtc_ctrl_i (
    .clock(clock),
    .rst(rst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dw),
    .wb_dat_o(dr),
    .wb_ack_o(ack),
    .hw_trigger_input(hwt),
    .core_result(core),
    .analog_power_r(pwr),
    .sample_r(smp),
    .convert_r(cnv),
    .mux_channel_r(mux),
    .temp_sensor_on_r(ts),
    .internal_ref_on_r(ir),
    .dma_req_r(dma),
    .irq_r(irq)
  );

  // same stimulus; the second converter must never ask for dma
  armtc_ctrl #(
    .SECOND_INSTANCE(1'b1)
  ) armtc_ctrl_second_i (
    .clock(clock),
    .rst(rst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dw),
    .wb_dat_o(),
    .wb_ack_o(),
    .hw_trigger_input(hwt),
    .core_result(core),
    .analog_power_r(),
    .sample_r(),
    .convert_r(),
    .mux_channel_r(),
    .temp_sensor_on_r(),
    .internal_ref_on_r(),
    .dma_req_r(dma2),
    .irq_r()
  );

  armtc_core_model armtc_core_model_i (
    .clock(clock),
    .convert_r(cnv),
    .level(lvl),
    .core_result(core)
  );

  task stop_test;
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one classic cycle; read data taken at the ack edge
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dw <= d;
    @(posedge clock);
    while (ack !== 1'h1)
      @(posedge clock);
    rdat = dr;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : bus

  // start by software write or hardware edge, count phase lengths
  task conv(input logic [11:0] v, input logic h, input logic [31:0] cb);
    lvl <= v;
    if (h)
    begin
      @(posedge clock);
      hwt <= 1'h1;
      @(posedge clock);
      hwt <= 1'h0;
    end
    else
      bus(1'h1, armtc_pkg::OFS_CTL_B, cb | 32'h0040_0000);
    s = 0;
    c = 0;
    while (dma !== 1'h1)
    begin
      @(posedge clock);
      s += (smp === 1'h1);
      c += (cnv === 1'h1);
      n2 += (dma2 !== 1'h0);
    end
  endtask : conv

  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    stop_test;
  end

  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    bus(1'h0, armtc_pkg::OFS_M0_HIGH, 32'h0000_0000);
    chk(rdat, 32'h0000_0FFF);
    bus(1'h0, armtc_pkg::OFS_M1_LIM, 32'h0000_0000);
    chk(rdat, 32'h0FFF_0000);
    bus(1'h1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'h0, 6'h3C, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    bus(1'h1, armtc_pkg::OFS_CTL_B, ON | SW | TI);
    repeat (2) @(posedge clock);
    chk({29'h0, ts, ir, pwr}, 32'h0000_0007);
    bus(1'h1, armtc_pkg::OFS_CHAN, 32'h0000_0010);
    bus(1'h1, armtc_pkg::OFS_M0_HIGH, 32'h0000_0800);
    bus(1'h1, armtc_pkg::OFS_M0_LOW, 32'h0000_0100);
    bus(1'h1, armtc_pkg::OFS_M1_LIM, 32'h0700_0200);
    bus(1'h1, armtc_pkg::OFS_M1_SEL, 32'h0001_0000);
    bus(1'h1, armtc_pkg::OFS_CTL_A, 32'h0080_0250);
    // sensor results right after power-up are thrown away
    repeat (3) conv(12'h000, 1'h0, ON | SW | TI);
    chk({27'h0, mux}, 32'h0000_0010);
    // resolution only moves while the converter is off
    for (int r = 0; r < 4; r++)
    begin
      bus(1'h1, armtc_pkg::OFS_CTL_B, SW | TI);
      bus(1'h1, armtc_pkg::OFS_OVS, 32'(r) << 2);
      conv(12'hABC, 1'h0, ON | SW | TI);
      chk(s, 3);
      chk(c, ct[r]);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1'h0, armtc_pkg::OFS_DATA, 32'h0000_0000);
      chk(rdat, {20'h0_0000, 12'hABC & (12'hFFF << (2 * r))});
    end
    bus(1'h1, armtc_pkg::OFS_OVS, 32'h0000_0000);
    bus(1'h0, armtc_pkg::OFS_OVS, 32'h0000_0000);
    chk(rdat, 32'h0000_000C);
    bus(1'h1, armtc_pkg::OFS_CTL_B, SW | TI);
    bus(1'h1, armtc_pkg::OFS_OVS, 32'h0000_0000);
    bus(1'h1, armtc_pkg::OFS_SAMP_B, 32'h0004_0000);
    bus(1'h0, armtc_pkg::OFS_SAMP_B, 32'h0000_0000);
    chk(rdat, 32'h0004_0000);
    conv(12'h123, 1'h0, ON | SW | TI);
    chk(s, 7);
    chk(c, 12);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'h1, armtc_pkg::OFS_STATUS, 32'h0000_0000);
      bus(1'h1, armtc_pkg::OFS_CTL_A, sa[i]);
      conv(sv[i], 1'h0, ON | SW | TI | (i == 1 ? 32'h0000_0800 : 32'h0));
      bus(1'h0, armtc_pkg::OFS_STATUS, 32'h0000_0000);
      chk(rdat, {29'h0, ss[i]});
      chk(irq, {31'h0, ss[i][0]});
      bus(1'h0, armtc_pkg::OFS_DATA, 32'h0000_0000);
      chk(rdat, {20'h0_0000, sd[i]});
    end
    bus(1'h1, armtc_pkg::OFS_STATUS, 32'h0000_0000);
    bus(1'h1, armtc_pkg::OFS_M1_SEL, 32'h0002_0000);
    bus(1'h1, armtc_pkg::OFS_CTL_A, 32'h0000_0000);
    bus(1'h1, armtc_pkg::OFS_CTL_B, ON | TI);
    conv(12'hFFF, 1'h1, 32'h0000_0000);
    bus(1'h0, armtc_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0004);
    bus(1'h1, armtc_pkg::OFS_CTL_B, 32'h0000_0000);
    repeat (2) @(posedge clock);
    chk({29'h0, ts, ir, pwr}, 32'h0000_0000);
    bus(1'h0, armtc_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk(n2, 0);
    stop_test;
  end
endmodule : armtc_ctrl_tb_top
